// *** hdl/spic_pkg.sv ***
/*
  Shared constants and types of the serial peripheral control block:
  register offsets, field positions, reset values, state codes.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package spic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [3:0]  ADDR_CTRL1  = 4'h0;
  localparam logic [3:0]  ADDR_CTRL2  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS = 4'h8;
  localparam logic [3:0]  ADDR_DATA   = 4'hc;

  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [15:0] CTRL1_MASK  = 16'h1fff;

  // Second control register fields
  localparam int          C2_ENABLE   = 0;
  localparam int          C2_FRAMED   = 15;

  // Status register fields
  localparam int          ST_RX_FULL  = 0;
  localparam int          ST_OVERRUN  = 1;
  localparam int          ST_BUSY     = 2;
  localparam int          ST_TX_FULL  = 3;
  localparam int          ST_TX_EMPTY = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Data path sizes
  localparam int          WORD_BITS   = 16;
  localparam int          TXF_DEPTH   = 8;
  localparam logic [4:0]  BITS_WORD   = 5'h10;
  localparam logic [4:0]  BITS_BYTE   = 5'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Layout of bits 12:0 of the first control register, MSB first
  typedef struct packed {
    logic       dis_clock_pin;
    logic       dis_data_pin;
    logic       word_width_select;
    logic       input_sample_phase;
    logic       out_edge_select;
    logic       select_pin_enable;
    logic       idle_level_select;
    logic       master_role_enable;
    logic [2:0] sec_prescale;
    logic [1:0] pri_prescale;
  } spic_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } spic_state_type;

endpackage

// *** hdl/spic_fifo.sv ***
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock; the drain side may stall for any time.
*/
module spic_fifo
  import spic_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// *** hdl/spic_spi_control.sv ***
/*
  Serial peripheral controller with its configuration register, a transmit
  FIFO, a receive holding register and a master/slave shift engine.
  Assumes an Avalon-MM master on clk, and a peer whose serial clock is slow
  enough (at least four clk periods per half period) to be oversampled.
*/
// The placing of the registers and register access over Avalon-MM were decided locally.
module spic_spi_control
  import spic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Serial link pins
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             sdo_out,
  output logic             sdo_oe,
  input  wire logic        sdi_in,
  input  wire logic        slave_select_pin_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and configuration
  logic [15:0]    spi_control_1;
  logic           spi_enable;
  logic           framed_operation_enable;
  logic           overrun;
  logic [15:0]    rx_data;
  logic           rx_full;
  logic           rd_ack;
  spic_cfg_type   cfg;
  spic_state_type state;

  assign cfg = spic_cfg_type'(spi_control_1[12:0]);

  logic       is_master;
  logic       edge_eff;
  logic [4:0] nbits;

  assign is_master = cfg.master_role_enable;
  assign edge_eff  = cfg.out_edge_select && !framed_operation_enable;
  assign nbits     = cfg.word_width_select ? BITS_WORD : BITS_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic        wr_data;
  logic        rd_data;
  logic        txf_in_ready;
  logic        txf_out_valid;
  logic        txf_pop;
  logic [15:0] txf_out_data;
  logic        rx_push;

  assign wr_data = write && (address == ADDR_DATA);
  assign rd_data = rd_ack && (address == ADDR_DATA);
  // Full FIFO stalls the master instead of dropping the word
  assign waitrequest = (read && !rd_ack) || (wr_data && !txf_in_ready);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_ack   <= 1'b0;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      rd_ack <= read && !rd_ack;
      if (read && !rd_ack)
      begin
        unique case (address)
          ADDR_CTRL1:  readdata <= {16'h0000, spi_control_1};
          ADDR_CTRL2:  readdata <= {16'h0000, framed_operation_enable, 14'h0000, spi_enable};
          ADDR_STATUS: readdata <= {27'h0000000, !txf_out_valid, !txf_in_ready,
                                    state != ST_IDLE, overrun, rx_full};
          ADDR_DATA:   readdata <= {16'h0000, rx_data};
          default:     readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      spi_control_1           <= CTRL1_RESET;
      spi_enable              <= 1'b0;
      framed_operation_enable <= 1'b0;
    end
    else if (write && address == ADDR_CTRL1)
    begin
      spi_control_1 <= writedata[15:0] & CTRL1_MASK;
    end
    else if (write && address == ADDR_CTRL2)
    begin
      spi_enable              <= writedata[C2_ENABLE];
      framed_operation_enable <= writedata[C2_FRAMED];
    end
  end

  // Receive holding register; a new word wins over a same-cycle read
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_full <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      if (rx_push)
      begin
        rx_full <= 1'b1;
      end
      else if (rd_data)
      begin
        rx_full <= 1'b0;
      end
      if (rx_push && rx_full && !rd_data)
      begin
        overrun <= 1'b1;
      end
      else if (write && address == ADDR_STATUS && writedata[ST_OVERRUN])
      begin
        overrun <= 1'b0;
      end
    end
  end

  spic_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (TXF_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (wr_data),
    .in_ready  (txf_in_ready),
    .in_data   (writedata[15:0]),
    .out_valid (txf_out_valid),
    .out_ready (txf_pop),
    .out_data  (txf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: 0 clock, 1 data in, 2 select
  logic [2:0] pin_raw;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       sck_prev;

  assign pin_raw = {slave_select_pin_n, sdi_in, sck_in};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        sync_a[i] <= 1'b1;
        sync_b[i] <= 1'b1;
      end
      else
      begin
        sync_a[i] <= pin_raw[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_prev <= 1'b1;
    end
    else
    begin
      sck_prev <= sync_b[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge events
  logic [5:0] half_period;
  logic [5:0] hp_cnt;
  logic [5:0] edge_cnt;
  logic       sck_act;
  logic       tick;
  logic       m_lead;
  logic       m_trail;
  logic       s_lead;
  logic       s_trail;
  logic       selected;
  logic       lead;
  logic       trail;
  logic       chg_ev;
  logic       mid_ev;
  logic       end_step;
  logic [4:0] chg_cnt;
  logic [4:0] samp_cnt;
  logic       shift_now;
  logic       samp_now;

  // Half period in clk cycles; at 1 the serial clock runs at clk/2
  assign half_period = ({3'h0, cfg.sec_prescale} + 6'h01) * ({4'h0, cfg.pri_prescale} + 6'h01);
  assign tick        = (state == ST_SHIFT) && (hp_cnt == half_period - 6'h01);
  assign end_step    = tick && (edge_cnt == {nbits, 1'b0});
  assign m_lead      = tick && !end_step && !sck_act;
  assign m_trail     = tick && !end_step && sck_act;
  // Active level is the opposite of the idle level
  assign s_lead  = (sync_b[0] ^ cfg.idle_level_select) && !(sck_prev ^ cfg.idle_level_select);
  assign s_trail = !(sync_b[0] ^ cfg.idle_level_select) && (sck_prev ^ cfg.idle_level_select);
  // Without select use the pin is left to port logic
  assign selected = !(cfg.select_pin_enable && !framed_operation_enable) || !sync_b[2];

  assign lead      = is_master ? m_lead  : s_lead;
  assign trail     = is_master ? m_trail : s_trail;
  assign chg_ev    = edge_eff ? trail : lead;
  assign mid_ev    = edge_eff ? lead  : trail;
  assign shift_now = chg_ev && (edge_eff || chg_cnt != 5'h00);
  // Late sampling is a master option only
  assign samp_now  = (samp_cnt != nbits) &&
                     ((is_master && cfg.input_sample_phase) ? (shift_now || end_step) : mid_ev);

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic        start;

  assign start   = (state == ST_IDLE) && spi_enable && (!is_master || txf_out_valid);
  assign txf_pop = start && txf_out_valid;
  assign rx_push = (state == ST_DONE);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state    <= ST_IDLE;
      hp_cnt   <= 6'h00;
      edge_cnt <= 6'h00;
      sck_act  <= 1'b0;
      chg_cnt  <= 5'h00;
      samp_cnt <= 5'h00;
      tx_sh    <= 16'h0000;
      rx_sh    <= 16'h0000;
      rx_data  <= 16'h0000;
    end
    else if (!spi_enable)
    begin
      state    <= ST_IDLE;
      sck_act  <= 1'b0;
      chg_cnt  <= 5'h00;
      samp_cnt <= 5'h00;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          hp_cnt   <= 6'h00;
          edge_cnt <= 6'h00;
          chg_cnt  <= 5'h00;
          samp_cnt <= 5'h00;
          if (start)
          begin
            // Byte data rides in the upper half so the MSB leads
            tx_sh <= !txf_out_valid ? 16'h0000 :
                     cfg.word_width_select ? txf_out_data : {txf_out_data[7:0], 8'h00};
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (!is_master && !selected)
          begin
            // Deselect aborts a partial word; loaded data is kept
            chg_cnt  <= 5'h00;
            samp_cnt <= 5'h00;
          end
          else
          begin
            if (is_master)
            begin
              hp_cnt <= tick ? 6'h00 : hp_cnt + 6'h01;
              if (tick && !end_step)
              begin
                sck_act  <= !sck_act;
                edge_cnt <= edge_cnt + 6'h01;
              end
            end
            if (samp_now)
            begin
              rx_sh    <= {rx_sh[14:0], sync_b[1]};
              samp_cnt <= samp_cnt + 5'h01;
            end
            if (chg_ev)
            begin
              chg_cnt <= chg_cnt + 5'h01;
            end
            if (shift_now)
            begin
              tx_sh <= {tx_sh[14:0], 1'b0};
            end
            if (is_master ? end_step : (samp_now && samp_cnt == nbits - 5'h01))
            begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE:
        begin
          rx_data <= cfg.word_width_select ? rx_sh : {8'h00, rx_sh[7:0]};
          state   <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  // Straight from the shift flops: an extra register would eat the slave's
  // margin at a four-cycle half period
  assign sck_out = cfg.idle_level_select ^ sck_act;
  assign sdo_out = tx_sh[15];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_oe  <= 1'b0;
      sdo_oe  <= 1'b0;
    end
    else
    begin
      sck_oe  <= spi_enable && is_master && !cfg.dis_clock_pin;
      sdo_oe  <= spi_enable && !cfg.dis_data_pin && (is_master || selected);
    end
  end

endmodule

// *** tb/spic_checker_assertions.sv ***
/*
  Port checker for the serial controller: bus timing, pin enables, clock idle level, edge choice, select gating.
  Assumes it is bound to spic_spi_control and sees only its ports.
*/
module spic_checker
  import spic_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Serial pins
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        sdo_out,
  input wire logic        sdo_oe,
  input wire logic        slave_select_pin_n
);
  spic_cfg_type cfg;
  logic         framed;
  logic         clk_ok;
  logic         select_pin_enable_eff;
  logic         cke_eff;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  //////////////////////////////////////////////////////////////
  // Shadow copies of the control fields, taken at accepted writes
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      cfg <= '0;
    else if (write && !waitrequest && address == ADDR_CTRL1)
      cfg <= writedata[12:0];

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      framed <= 1'b0;
    else if (write && !waitrequest && address == ADDR_CTRL2)
      framed <= writedata[C2_FRAMED];

  assign clk_ok   = cfg.master_role_enable && !cfg.dis_clock_pin;
  assign select_pin_enable_eff = cfg.select_pin_enable && !framed && !cfg.master_role_enable;
  assign cke_eff  = cfg.out_edge_select && !framed;

  //////////////////////////////////////////////////////////////
  read_wait_a: assert property (read && waitrequest |=> !waitrequest)
    else $error("read held more than one wait state");
  write_nowait_a: assert property (write && address != ADDR_DATA |-> !waitrequest)
    else $error("register write stalled");
  unmapped_zero_a: assert property (read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (read && !waitrequest && address == ADDR_CTRL1 |-> readdata == {19'h0, cfg})
    else $error("control readback differs from written fields");
  clk_drive_a: assert property (sck_oe |-> $past(clk_ok))
    else $error("clock driven outside master role");
  idle_level_a: assert property ($rose(sck_oe) |-> sck_out == cfg.idle_level_select)
    else $error("clock not at idle level when driven");
  out_edge_a: assert property (sck_oe && sdo_oe && $changed(sck_out) && $changed(sdo_out)
    |-> sck_out == (cke_eff ? cfg.idle_level_select : !cfg.idle_level_select))
    else $error("data changed on the wrong clock edge");
  select_gate_a: assert property (sdo_oe && $past(select_pin_enable_eff) |-> !$past(slave_select_pin_n, 3))
    else $error("data driven while deselected");

  cover property (write && waitrequest);
  cover property ($rose(sck_oe));
  cover property (sdo_oe && !sck_oe && $past(select_pin_enable_eff));
endmodule

bind spic_spi_control spic_checker chk
(
  .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
  .sdo_oe(sdo_oe), .slave_select_pin_n(slave_select_pin_n)
);

// *** tb/spic_peer.sv ***
/*
  Far-side serial device: answers as slave when the block is master, frames as master otherwise.
  Assumes the bench sets role, idle level, edge choice and word length.
*/
module spic_peer
  import spic_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Pins of the block
  input  wire logic       sck_out,
  input  wire logic       sck_oe,
  input  wire logic       sdo_out,
  input  wire logic       sdo_oe,
  output logic            sck_in,
  output logic            sdi_in,
  // Link settings
  input  wire logic       dut_master,
  input  wire logic       idle,
  input  wire logic       cke,
  input  wire logic [4:0] nbits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tx_w = 16'h0;
  logic [15:0] shr = 16'h0;
  logic [15:0] rx_q[$];
  logic        prev_sck = 1'b0;
  logic        act = 1'b0;
  logic        sdi_s = 1'b0;
  int          k = 0;

  // Clock stands at idle outside frames
  assign sck_in = act ^ idle;
  assign sdi_in = dut_master ? tx_w[int'(nbits) - 1 - k] : sdi_s;

  // Sample on the edge opposite the shifting one; undriven data reads as unknown
  always @(posedge clk)
  begin
    prev_sck <= sck_out;
    if (dut_master && sck_oe && sck_out != prev_sck && sck_out == (cke ? !idle : idle))
    begin
      shr = {shr[14:0], sdo_oe ? sdo_out : 1'bx};
      k = k + 1;
      if (k == int'(nbits))
      begin
        rx_q.push_back(nbits == BITS_WORD ? shr : {8'h0, shr[7:0]});
        k = 0;
      end
    end
  end

  // Half period of four clk cycles
  task automatic xfer(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0;
    for (int i = int'(nbits) - 1; i >= 0; i--)
    begin
      // Data changes on the edge opposite the sampling one
      if (cke)
        sdi_s <= w[i];
      repeat (4) @(posedge clk);
      act <= 1'b1;
      if (!cke)
        sdi_s <= w[i];
      if (cke)
        r = {r[14:0], sdo_oe ? sdo_out : 1'bx};
      repeat (4) @(posedge clk);
      act <= 1'b0;
      if (!cke)
        r = {r[14:0], sdo_oe ? sdo_out : 1'bx};
    end
    rx_q.push_back(r);
    sdi_s <= ~w[0];
  endtask
endmodule

// *** tb/tb.sv ***
/*
  Self-checking bench for spic_spi_control: register bus, master and slave transfers, FIFO fill.
  Assumes the checker is bound and spic_peer models the far side.
*/
module tb
  import spic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(got, exp) begin logic [31:0] g_v; g_v = 32'(got); n_compared++; \
    if (g_v !== 32'(exp)) begin errors++; \
    $display("mismatch at %0t: got %h, expected %h", $time, g_v, 32'(exp)); end end

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        slave_select_pin_n = 1'b1;
  logic [31:0] readdata;
  logic        waitrequest, sck_out, sck_oe, sdo_out, sdo_oe, sck_in, sdi_in;
  logic        dut_master = 1'b0, idle = 1'b0, cke = 1'b0, m16, fr;
  logic [4:0]  nbits = BITS_BYTE;
  logic [31:0] r;
  logic [15:0] w0, w1;
  logic [15:0] q[10];
  int          errors = 0;
  int          n_compared = 0;

  always #10 clk = ~clk;

  spic_spi_control DUT (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdi_in(sdi_in),
    .slave_select_pin_n(slave_select_pin_n));
  spic_peer peer (.clk(clk), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .sck_in(sck_in), .sdi_in(sdi_in), .dut_master(dut_master), .idle(idle), .cke(cke), .nbits(nbits));

  //////////////////////////////////////////////////////////////
  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask

  task wait_idle;
    logic [31:0] s;
    do bus_rd(ADDR_STATUS, s); while (s[ST_BUSY] !== 1'b0 || s[ST_TX_EMPTY] !== 1'b1);
  endtask

  // Disables first; prescale kept at four clk or more per half bit
  task set_cfg(input logic w16, mst, ck, cp, ss, frm);
    bus_wr(ADDR_CTRL2, 32'h0);
    bus_wr(ADDR_CTRL1, {19'h0, 2'b00, w16, 1'b0, ck, ss, cp, mst, 3'($urandom_range(1, 3)), 2'h1});
    dut_master <= mst;
    idle <= cp;
    cke <= ck && !frm;
    nbits <= w16 ? BITS_WORD : BITS_BYTE;
  endtask

  function automatic logic [15:0] exp_w(input logic [15:0] w, input logic w16);
    return w16 ? w : {8'h0, w[7:0]};
  endfunction

  task complete_run;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h6ce1));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    bus_rd(ADDR_STATUS, r);
    `CHK(r, 32'h10)
    bus_wr(4'h2, 32'hffff);
    bus_rd(ADDR_CTRL1, r);
    `CHK(r, CTRL1_RESET)
    bus_rd(4'h6, r);
    `CHK(r, 32'h0)
    r = $urandom;
    bus_wr(ADDR_CTRL1, r);
    w0 = r[15:0];
    bus_rd(ADDR_CTRL1, r);
    `CHK(r, w0 & CTRL1_MASK)
    // Every edge and polarity pair, then framed with the edge bit wrongly set
    for (int t = 0; t < 6; t++)
    begin
      m16 = 1'($urandom);
      fr = (t == 5);
      set_cfg(m16, 1'b1, t[0] | fr, t[1], 1'b0, fr);
      peer.tx_w = 16'($urandom);
      w0 = 16'($urandom);
      w1 = 16'($urandom);
      bus_wr(ADDR_CTRL2, {16'h0, fr, 14'h0, 1'b1});
      bus_wr(ADDR_DATA, {16'h0, w0});
      bus_wr(ADDR_DATA, {16'h0, w1});
      wait_idle();
      `CHK(peer.rx_q.pop_front(), exp_w(w0, m16))
      `CHK(peer.rx_q.pop_front(), exp_w(w1, m16))
      bus_rd(ADDR_STATUS, r);
      `CHK(r[1:0], 2'b11)
      bus_rd(ADDR_DATA, r);
      `CHK(r, exp_w(peer.tx_w, m16))
      bus_wr(ADDR_STATUS, 32'h2);
      bus_rd(ADDR_STATUS, r);
      `CHK(r, 32'h10)
    end
    // Fill while disabled, then the tenth word must stall until a slot frees
    set_cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 10; i++)
      q[i] = 16'($urandom);
    for (int i = 0; i < 8; i++)
      bus_wr(ADDR_DATA, {16'h0, q[i]});
    bus_rd(ADDR_STATUS, r);
    `CHK(r[4:3], 2'b01)
    bus_wr(ADDR_CTRL2, 32'h1);
    bus_wr(ADDR_DATA, {16'h0, q[8]});
    bus_wr(ADDR_DATA, {16'h0, q[9]});
    wait_idle();
    for (int i = 0; i < 10; i++)
      `CHK(peer.rx_q.pop_front(), q[i])
    // Slave role: select pin ignored, then honoured
    for (int t = 0; t < 2; t++)
    begin
      m16 = 1'($urandom);
      set_cfg(m16, 1'b0, 1'($urandom), 1'($urandom), t[0], 1'b0);
      w0 = 16'($urandom);
      w1 = 16'($urandom);
      bus_wr(ADDR_DATA, {16'h0, w0});
      slave_select_pin_n <= !t[0];
      bus_wr(ADDR_CTRL2, 32'h1);
      repeat (4) @(posedge clk);
      peer.xfer(w1);
      repeat (8) @(posedge clk);
      `CHK(peer.rx_q.pop_front(), exp_w(w0, m16))
      bus_rd(ADDR_DATA, r);
      `CHK(r, exp_w(w1, m16))
      slave_select_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(sdo_oe, !t[0])
    end
    complete_run();
  end
endmodule
